// [hdl/legacy_text_graphics_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module legacy_text_graphics_regs
(
    // Clock and reset
    input  wire logic                           ref_clk,
    input  wire logic                           resetn,
    // Host I/O port
    input  wire legacy_regs_pkg::io_req_t       io_req,
    output var  logic [7:0]                     io_rdata,
    // Personality and base select
    input  wire legacy_regs_pkg::compat_t       compat_mode,
    input  wire logic                           colour_base,
    // CRT timing (from the same clock domain)
    input  wire logic [13:0]                    display_addr,
    input  wire logic                           blanking_active,
    input  wire logic                           horizontal_blank_state,
    input  wire logic                           vertical_sync_state,
    input  wire logic                           mono_video_enabled,
    // Pixel palette path
    input  wire logic [1:0]                     pixel_code,
    output var  logic [3:0]                     pixel_irgb,
    output var  logic [3:0]                     border_irgb,
    // Display controls
    output var  legacy_regs_pkg::display_ctrl_t display_ctrl,
    output var  logic                           pen_flag
);

    // ==========================================================
    // Register state
    logic [7:0]  colour_mode_ctrl_q;
    logic [7:0]  colour_palette_select_q;
    logic [7:0]  mono_mode_q;
    logic [7:0]  mono_graphics_permit_q;
    logic [7:0]  crt_index_q;
    logic        pen_flag_q;
    logic [13:0] pen_addr_q;

    // ==========================================================
    // Address decode
    wire logic mono_map     = !colour_base;
    wire logic colour_pers  = compat_mode == legacy_regs_pkg::MODE_COLOUR;
    wire logic hgc_pers     = compat_mode == legacy_regs_pkg::MODE_MONO_GRAPH;
    wire logic latch_pers   = colour_pers || hgc_pers;
    wire logic hit_cidx     = io_req.addr == (mono_map ? legacy_regs_pkg::PORT_CRT_INDEX_MONO
                                                       : legacy_regs_pkg::PORT_CRT_INDEX_COLOUR);
    wire logic hit_cdata    = io_req.addr == (mono_map ? legacy_regs_pkg::PORT_CRT_DATA_MONO
                                                       : legacy_regs_pkg::PORT_CRT_DATA_COLOUR);
    wire logic hit_cmode    = !mono_map && io_req.addr == legacy_regs_pkg::PORT_COLOUR_MODE;
    wire logic hit_csel     = !mono_map && io_req.addr == legacy_regs_pkg::PORT_COLOUR_SELECT;
    wire logic hit_cstate   = !mono_map && io_req.addr == legacy_regs_pkg::PORT_COLOUR_STATE;
    wire logic hit_mmode    = mono_map && io_req.addr == legacy_regs_pkg::PORT_MONO_MODE;
    wire logic hit_mstate   = mono_map && io_req.addr == legacy_regs_pkg::PORT_MONO_STATE;
    wire logic hit_permit   = mono_map && io_req.addr == legacy_regs_pkg::PORT_MONO_PERMIT;
    wire logic hit_set      = io_req.addr == (mono_map ? legacy_regs_pkg::PORT_MONO_PEN_SET
                                                       : legacy_regs_pkg::PORT_COLOUR_PEN_SET);
    wire logic hit_clear    = io_req.addr == (mono_map ? legacy_regs_pkg::PORT_MONO_PEN_CLEAR
                                                       : legacy_regs_pkg::PORT_COLOUR_PEN_CLEAR);

    wire logic wr_set       = io_req.wr && hit_set;
    wire logic wr_clear     = io_req.wr && hit_clear;
    // Set wins when both arrive together
    wire logic pen_flag_d   = wr_set || (pen_flag_q && !wr_clear);
    // Capture only on the rising edge of the flag
    wire logic pen_capture  = wr_set && !pen_flag_q && latch_pers;

    // Upper page bit held clear unless permitted
    wire logic [7:0] mono_wmask = hgc_pers ? legacy_regs_pkg::MONO_GMODE_MASK
                                           : legacy_regs_pkg::MONO_MODE_MASK;
    wire logic [7:0] mono_wdata = (io_req.wdata & mono_wmask)
                                  & ~({7'h00, !mono_graphics_permit_q[legacy_regs_pkg::PERMIT_UPPER]}
                                      << legacy_regs_pkg::MM_PAGE);

    // ==========================================================
    // Write side
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            colour_mode_ctrl_q      <= legacy_regs_pkg::RESET_BYTE;
            colour_palette_select_q <= legacy_regs_pkg::RESET_BYTE;
            mono_mode_q             <= legacy_regs_pkg::RESET_BYTE;
            mono_graphics_permit_q  <= legacy_regs_pkg::RESET_BYTE;
            crt_index_q             <= legacy_regs_pkg::RESET_BYTE;
            pen_flag_q              <= 1'b0;
            pen_addr_q              <= 14'h0000;
        end
        else
        begin
            if (io_req.wr && hit_cmode)
                colour_mode_ctrl_q <= io_req.wdata & legacy_regs_pkg::CMODE_MASK;
            if (io_req.wr && hit_csel)
                colour_palette_select_q <= io_req.wdata & legacy_regs_pkg::CSEL_MASK;
            if (io_req.wr && hit_mmode)
                mono_mode_q <= mono_wdata;
            if (io_req.wr && hit_permit)
                mono_graphics_permit_q <= io_req.wdata;
            if (io_req.wr && hit_cidx)
                crt_index_q <= io_req.wdata;
            pen_flag_q <= pen_flag_d;
            if (pen_capture)
                pen_addr_q <= display_addr;
        end
    end

    // ==========================================================
    // Status bytes
    wire logic [7:0] colour_state = legacy_regs_pkg::COLOUR_ST_ONES
                                  | {4'h0, vertical_sync_state, 1'b0, pen_flag_q,
                                     blanking_active};
    wire logic [7:0] mono_g_state = legacy_regs_pkg::MONO_G_ST_ONES
                                  | {!vertical_sync_state, 3'h0, mono_video_enabled, 1'b0,
                                     pen_flag_q, horizontal_blank_state};
    wire logic [7:0] mono_t_state = legacy_regs_pkg::MONO_T_ST_ONES
                                  | {4'h0, mono_video_enabled, 2'h0,
                                     horizontal_blank_state};

    // Pen address hidden in VGA personality
    wire logic pen_visible = latch_pers && hit_cdata;
    wire logic [7:0] pen_byte = (crt_index_q == legacy_regs_pkg::IDX_PEN_HIGH)
                                ? {2'b00, pen_addr_q[13:8]} : pen_addr_q[7:0];
    wire logic pen_index = crt_index_q == legacy_regs_pkg::IDX_PEN_HIGH
                        || crt_index_q == legacy_regs_pkg::IDX_PEN_LOW;

    // Mode registers read back so software can verify them
    wire logic [7:0] rdata_d =
        (pen_visible && pen_index)    ? pen_byte :
        hit_cidx                      ? crt_index_q :
        hit_cmode                     ? colour_mode_ctrl_q :
        hit_csel                      ? colour_palette_select_q :
        hit_cstate                    ? colour_state :
        hit_mmode                     ? mono_mode_q :
        (hit_mstate && hgc_pers)      ? mono_g_state :
        hit_mstate                    ? mono_t_state :
                                        legacy_regs_pkg::UNMAPPED_READ;

    // ==========================================================
    // Display control decode
    wire logic eff_graph_m = hgc_pers && mono_mode_q[legacy_regs_pkg::MM_GRAPHICS]
                             && mono_graphics_permit_q[legacy_regs_pkg::PERMIT_GRAPH];
    legacy_regs_pkg::display_ctrl_t ctrl_d;
    always_comb
    begin
        ctrl_d = '0;
        if (colour_pers)
        begin
            ctrl_d.wide_text_select     = colour_mode_ctrl_q[legacy_regs_pkg::CM_WIDE_TEXT];
            ctrl_d.graphics_select      = colour_mode_ctrl_q[legacy_regs_pkg::CM_GRAPHICS];
            ctrl_d.fine_graphics_select = colour_mode_ctrl_q[legacy_regs_pkg::CM_FINE_GRAPH];
            ctrl_d.video_on             = colour_mode_ctrl_q[legacy_regs_pkg::CM_VIDEO_ON];
            ctrl_d.blink_on             = colour_mode_ctrl_q[legacy_regs_pkg::CM_BLINK_ON];
            ctrl_d.columns_code         = {1'b0, ctrl_d.wide_text_select};
        end
        else
        begin
            ctrl_d.wide_text_select     = 1'b1;
            ctrl_d.graphics_select      = eff_graph_m;
            ctrl_d.video_on             = mono_mode_q[legacy_regs_pkg::MM_VIDEO_ON];
            ctrl_d.blink_on             = mono_mode_q[legacy_regs_pkg::MM_BLINK_ON];
            ctrl_d.display_page_select  = hgc_pers && mono_mode_q[legacy_regs_pkg::MM_PAGE];
            ctrl_d.columns_code         = {eff_graph_m, 1'b1};
        end
    end

    // ==========================================================
    // Palette path
    wire logic [3:0] sel_irgb   = colour_palette_select_q[legacy_regs_pkg::CS_INTENSITY:0];
    wire logic       bright     = colour_palette_select_q[legacy_regs_pkg::CS_ALT_SET];
    wire logic       pal_alt    = colour_palette_select_q[legacy_regs_pkg::CS_PALETTE];
    wire logic       no_colour  = colour_mode_ctrl_q[legacy_regs_pkg::CM_NO_COLOUR];
    wire logic       graph_on   = colour_mode_ctrl_q[legacy_regs_pkg::CM_GRAPHICS];
    wire logic       fine_on    = colour_mode_ctrl_q[legacy_regs_pkg::CM_FINE_GRAPH];
    // Colour off forces the cyan/red/white set
    wire logic [1:0] set_sel    = no_colour ? 2'd2 : {1'b0, pal_alt};
    logic [3:0] pix_d;
    always_comb
    begin
        pix_d = sel_irgb;
        if (graph_on && fine_on)
            pix_d = pixel_code[0] ? sel_irgb : legacy_regs_pkg::IRGB_BLACK;
        else if (graph_on && pixel_code != 2'b00)
        begin
            unique case (set_sel)
                2'd0:    pix_d = {bright, 3'b000} | ((pixel_code == 2'b01) ? 4'h2 :
                                  (pixel_code == 2'b10) ? 4'h4 : 4'h6);
                2'd1:    pix_d = {bright, 3'b000} | ((pixel_code == 2'b01) ? 4'h3 :
                                  (pixel_code == 2'b10) ? 4'h5 : 4'h7);
                default: pix_d = {bright, 3'b000} | ((pixel_code == 2'b01) ? 4'h3 :
                                  (pixel_code == 2'b10) ? 4'h4 : 4'h7);
            endcase
        end
    end
    // In 640 mode the border stays black since select bits are foreground
    wire logic [3:0] border_d = (graph_on && fine_on) ? legacy_regs_pkg::IRGB_BLACK : sel_irgb;

    // ==========================================================
    // Registered outputs
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            io_rdata     <= legacy_regs_pkg::RESET_BYTE;
            pixel_irgb   <= legacy_regs_pkg::IRGB_BLACK;
            border_irgb  <= legacy_regs_pkg::IRGB_BLACK;
            display_ctrl <= '0;
            pen_flag     <= 1'b0;
        end
        else
        begin
            if (io_req.rd)
                io_rdata <= rdata_d;
            pixel_irgb   <= pix_d;
            border_irgb  <= border_d;
            display_ctrl <= ctrl_d;
            pen_flag     <= pen_flag_d;
        end
    end

endmodule : legacy_text_graphics_regs
`default_nettype wire

// [hdl/legacy_regs_pkg.sv]
// Notes on behaviour
// - Latch 14-bit address in colour/mono-graphics modes
// - Pen address unreadable while in VGA mode
// - Colour mode bit0 picks 40 or 80 columns
// - Bit1 graphics select; bit4 enables 640x200
// - Bit3 blanks or enables video; bit5 blinks
// - Colour off: 320 pixels background/cyan/red/white
// - 640 mode: 0 black, 1 select colour
// - Select bits 0-3 add blue/green/red/intensity
// - Select bit4 background text or bright set
// - Select bit5 picks 320x200 palette set
// - Colour status: blank, flag, 1, vsync, ones
// - Any write sets or clears pen flag
// - Flag set stores current display address
// - Mono mode bit3 video on, bit5 blink
// - Mono graphics bit1 text or 720x348 graphics
// - Mono bit7 shows page 0 or page 1
// - Mono graphics status with inverted vertical sync
// - Plain mono status: hblank, video test, ones
// - Config bit0 forces text or permits graphics
// - Config bit1 gates mode bit7 upper page
// - Misc bit0 chooses mono or colour base
`default_nettype none
package legacy_regs_pkg;

    // ==========================================================
    // Port addresses and indices
    localparam logic [9:0] PORT_CRT_INDEX_MONO   = 10'h3B4;
    localparam logic [9:0] PORT_CRT_DATA_MONO    = 10'h3B5;
    localparam logic [9:0] PORT_MONO_MODE        = 10'h3B8;
    localparam logic [9:0] PORT_MONO_PEN_SET     = 10'h3B9;
    localparam logic [9:0] PORT_MONO_STATE       = 10'h3BA;
    localparam logic [9:0] PORT_MONO_PEN_CLEAR   = 10'h3BB;
    localparam logic [9:0] PORT_MONO_PERMIT      = 10'h3BF;
    localparam logic [9:0] PORT_CRT_INDEX_COLOUR = 10'h3D4;
    localparam logic [9:0] PORT_CRT_DATA_COLOUR  = 10'h3D5;
    localparam logic [9:0] PORT_COLOUR_MODE      = 10'h3D8;
    localparam logic [9:0] PORT_COLOUR_SELECT    = 10'h3D9;
    localparam logic [9:0] PORT_COLOUR_STATE     = 10'h3DA;
    localparam logic [9:0] PORT_COLOUR_PEN_CLEAR = 10'h3DB;
    localparam logic [9:0] PORT_COLOUR_PEN_SET   = 10'h3DC;
    localparam logic [7:0] IDX_PEN_HIGH          = 8'h10;
    localparam logic [7:0] IDX_PEN_LOW           = 8'h11;

    // ==========================================================
    // Field positions
    localparam int CM_WIDE_TEXT   = 0;
    localparam int CM_GRAPHICS    = 1;
    localparam int CM_NO_COLOUR   = 2;
    localparam int CM_VIDEO_ON    = 3;
    localparam int CM_FINE_GRAPH  = 4;
    localparam int CM_BLINK_ON    = 5;
    localparam int CS_INTENSITY   = 3;
    localparam int CS_ALT_SET     = 4;
    localparam int CS_PALETTE     = 5;
    localparam int MM_GRAPHICS    = 1;
    localparam int MM_VIDEO_ON    = 3;
    localparam int MM_BLINK_ON    = 5;
    localparam int MM_PAGE        = 7;
    localparam int PERMIT_GRAPH   = 0;
    localparam int PERMIT_UPPER   = 1;

    // ==========================================================
    // Reset values and constant status bits
    localparam logic [7:0] RESET_BYTE       = 8'h00;
    localparam logic [7:0] MONO_MODE_MASK   = 8'h28;
    localparam logic [7:0] MONO_GMODE_MASK  = 8'hAA;
    localparam logic [7:0] CMODE_MASK       = 8'h3F;
    localparam logic [7:0] CSEL_MASK        = 8'h3F;
    localparam logic [7:0] COLOUR_ST_ONES   = 8'hF4;
    localparam logic [7:0] MONO_G_ST_ONES   = 8'h74;
    localparam logic [7:0] MONO_T_ST_ONES   = 8'hF6;
    localparam logic [7:0] UNMAPPED_READ    = 8'hFF;
    localparam logic [3:0] IRGB_BLACK       = 4'h0;

    // Compatibility personality in force
    typedef enum logic [1:0] {MODE_VGA, MODE_COLOUR, MODE_MONO_TEXT, MODE_MONO_GRAPH} compat_t;

    // Decoded display controls for the CRT and palette logic
    typedef struct packed {
        logic       wide_text_select;
        logic       graphics_select;
        logic       fine_graphics_select;
        logic       video_on;
        logic       blink_on;
        logic       display_page_select;
        logic [1:0] columns_code;
    } display_ctrl_t;

    // Host I/O cycle
    typedef struct packed {
        logic [9:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } io_req_t;

endpackage : legacy_regs_pkg
`default_nettype wire

// [tb/legacy_regs_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module legacy_regs_chk
(
    // Clock and reset
    input wire logic                           ref_clk,
    input wire logic                           resetn,
    // Watched ports
    input wire legacy_regs_pkg::io_req_t       io_req,
    input wire logic [7:0]                     io_rdata,
    input wire legacy_regs_pkg::compat_t       compat_mode,
    input wire logic                           colour_base,
    input wire logic                           blanking_active,
    input wire logic                           horizontal_blank_state,
    input wire logic                           vertical_sync_state,
    input wire logic                           mono_video_enabled,
    input wire legacy_regs_pkg::display_ctrl_t display_ctrl,
    input wire logic                           pen_flag
);
    // ==========================================
    // Host cycle decode
    wire logic set_hit = io_req.wr && io_req.addr == (colour_base ? 10'h3DC : 10'h3B9);
    wire logic clr_hit = io_req.wr && io_req.addr == (colour_base ? 10'h3DB : 10'h3BB);
    wire logic no_vga  = compat_mode != legacy_regs_pkg::MODE_VGA;
    wire logic is_col  = compat_mode == legacy_regs_pkg::MODE_COLOUR;
    wire logic rd_cst  = io_req.rd && colour_base && io_req.addr == 10'h3DA && is_col;
    wire logic rd_mst  = io_req.rd && !colour_base && io_req.addr == 10'h3BA;
    wire logic wr_cm   = io_req.wr && colour_base && io_req.addr == 10'h3D8 && is_col;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    a_pen_set: assert property (set_hit && no_vga |=> pen_flag)
        else $error("pen flag not set by set port");
    a_pen_clear: assert property (clr_hit && no_vga |=> !pen_flag)
        else $error("pen flag not cleared by clear port");
    a_flag_hold: assert property (!set_hit && !clr_hit |=> $stable(pen_flag))
        else $error("pen flag moved without a flag write");
    a_colour_stat: assert property (rd_cst |=> io_rdata == {4'hF, $past(vertical_sync_state),
        1'h1, $past(pen_flag), $past(blanking_active)}) else $error("colour status mismatch");
    a_graph_stat: assert property (rd_mst && compat_mode == legacy_regs_pkg::MODE_MONO_GRAPH
        |=> io_rdata == {!$past(vertical_sync_state), 3'h7, $past(mono_video_enabled), 1'h1,
        $past(pen_flag), $past(horizontal_blank_state)}) else $error("graphics status mismatch");
    a_text_stat: assert property (rd_mst && compat_mode == legacy_regs_pkg::MODE_MONO_TEXT
        |=> io_rdata == {4'hF, $past(mono_video_enabled), 2'h3, $past(horizontal_blank_state)})
        else $error("text status mismatch");
    a_vga_pen: assert property (io_req.rd && !no_vga
        && io_req.addr == (colour_base ? 10'h3D5 : 10'h3B5) |=> io_rdata == 8'hFF)
        else $error("pen address readable in vga mode");
    a_mode_decode: assert property (wr_cm |=> ##1
        {display_ctrl.blink_on, display_ctrl.fine_graphics_select, display_ctrl.video_on,
        display_ctrl.graphics_select, display_ctrl.wide_text_select}
        == {$past(io_req.wdata[5:3], 2), $past(io_req.wdata[1:0], 2)})
        else $error("colour mode decode mismatch");

    c_pen_set: cover property (set_hit && !pen_flag);
    c_colour_stat: cover property (rd_cst);
    c_upper_page: cover property (display_ctrl.display_page_select);
endmodule : legacy_regs_chk

bind legacy_text_graphics_regs legacy_regs_chk i_legacy_regs_chk
(
    .ref_clk(ref_clk), .resetn(resetn), .io_req(io_req), .io_rdata(io_rdata),
    .compat_mode(compat_mode), .colour_base(colour_base), .blanking_active(blanking_active),
    .horizontal_blank_state(horizontal_blank_state), .vertical_sync_state(vertical_sync_state),
    .mono_video_enabled(mono_video_enabled), .display_ctrl(display_ctrl), .pen_flag(pen_flag)
);
`default_nettype wire

// [tb/host_io_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_io_model
(
    // Clock
    input  wire logic                     ref_clk,
    // Retrace seen by software
    input  wire logic                     vertical_sync_state,
    // I/O cycle
    output var  legacy_regs_pkg::io_req_t io_req,
    input  wire logic [7:0]               io_rdata
);
    // ==========================================
    // One-cycle strobes, launched at the falling edge
    initial io_req = '0;

    task automatic io_write(input logic [9:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        io_req = '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(negedge ref_clk);
        io_req.wr    = 1'h0;
        io_req.wdata = ~d;
    endtask : io_write

    task automatic io_read(input logic [9:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        io_req.addr = a;
        io_req.rd   = 1'h1;
        @(negedge ref_clk);
        io_req.rd = 1'h0;
        d         = io_rdata;
    endtask : io_read

    // Software pen sample; b is the 3B0 or 3D0 base
    task automatic pen_sample(input logic [9:0] b, output logic [15:0] a);
        int n;
        io_write(b[6] ? 10'h3DB : 10'h3BB, 8'h5A);
        for (n = 0; n < 1000 && !vertical_sync_state; n++) @(negedge ref_clk);
        io_write(b[6] ? 10'h3DC : 10'h3B9, 8'hA5);
        io_write(b + 10'h004, 8'h10);
        io_read(b + 10'h005, a[15:8]);
        io_write(b + 10'h004, 8'h11);
        io_read(b + 10'h005, a[7:0]);
    endtask : pen_sample
endmodule : host_io_model
`default_nettype wire

// [tb/legacy_text_graphics_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module legacy_text_graphics_regs_tb;
    // ==========================================
    // Signals
    logic                                ref_clk      = 1'h0;
    logic                                resetn       = 1'h0;
    legacy_regs_pkg::compat_t            compat_mode  = legacy_regs_pkg::MODE_COLOUR;
    logic                                colour_base  = 1'h1;
    logic [13:0]                         display_addr = 14'h0000;
    logic [3:0]                          crt          = 4'h0;
    logic [1:0]                          pixel_code   = 2'h0;
    wire legacy_regs_pkg::io_req_t       io_req;
    wire logic [7:0]                     io_rdata;
    wire logic [3:0]                     pixel_irgb;
    wire logic [3:0]                     border_irgb;
    wire legacy_regs_pkg::display_ctrl_t display_ctrl;
    wire logic                           pen_flag;
    logic [31:0] seed = 32'h000119F0;
    logic [31:0] r, rs;
    logic [13:0] exp_pen;
    logic [3:0]  exp_px, crt_s;
    logic [7:0]  rd_v, mreg, sreg;
    logic [15:0] pen_v;
    logic        exp_flag, skip;
    logic        frz = 1'h0;
    logic        pal_chk = 1'h0;
    logic [7:0]  pal_mode [3] = '{8'h0A, 8'h0E, 8'h1A};
    int          errors = 0;
    int          check_count = 0;

    legacy_text_graphics_regs i_legacy_text_graphics_regs
    (
        .ref_clk(ref_clk), .resetn(resetn), .io_req(io_req), .io_rdata(io_rdata),
        .compat_mode(compat_mode), .colour_base(colour_base), .display_addr(display_addr),
        .blanking_active(crt[3]), .horizontal_blank_state(crt[2]),
        .vertical_sync_state(crt[1]), .mono_video_enabled(crt[0]), .pixel_code(pixel_code),
        .pixel_irgb(pixel_irgb), .border_irgb(border_irgb), .display_ctrl(display_ctrl),
        .pen_flag(pen_flag)
    );
    host_io_model i_host_io_model
    (
        .ref_clk(ref_clk), .vertical_sync_state(crt[1]), .io_req(io_req), .io_rdata(io_rdata)
    );

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Code 00 takes the select colour outside 640 mode; 640 mode is checked on codes 00 and 11 only
    function automatic logic [3:0] exp_pix(input logic [7:0] m, s, input logic [1:0] c);
        logic [2:0] p;
        p = {c, s[5] | m[2]};
        if (m[2] && c == 2'h2)
            p = 3'h4;
        if (m[4])
            return c[0] ? s[3:0] : 4'h0;
        return (c == 2'h0) ? s[3:0] : {s[4], p};
    endfunction : exp_pix

    // Status byte for the base and personality in force
    function automatic logic [7:0] exp_st(input logic c, input logic [3:0] t);
        if (c)
            return {4'hF, t[1], 1'h1, exp_flag, t[3]};
        if (compat_mode == legacy_regs_pkg::MODE_MONO_GRAPH)
            return {!t[1], 3'h7, t[0], 1'h1, exp_flag, t[2]};
        return {4'hF, t[0], 2'h3, t[2]};
    endfunction : exp_st

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    initial forever #10 ref_clk = ~ref_clk;

    // ==========================================
    // Reference flag, latch and palette
    always @(posedge ref_clk or negedge resetn)
        if (!resetn)
            exp_flag <= 1'h0;
        else
        begin
            if (io_req.wr && io_req.addr == (colour_base ? 10'h3DC : 10'h3B9))
            begin
                if (!exp_flag && compat_mode inside {legacy_regs_pkg::MODE_COLOUR,
                    legacy_regs_pkg::MODE_MONO_GRAPH})
                    exp_pen <= display_addr;
                exp_flag <= 1'h1;
            end
            else if (io_req.wr && io_req.addr == (colour_base ? 10'h3DB : 10'h3BB))
                exp_flag <= 1'h0;
            exp_px <= exp_pix(mreg, sreg, pixel_code);
            skip   <= mreg[4] && ^pixel_code;
            crt_s  <= crt;
        end

    always @(negedge ref_clk)
    begin
        rs = rnd();
        display_addr <= rs[13:0];
        pixel_code   <= rs[15:14];
        crt          <= frz ? 4'h0 : rs[19:16];
        if (resetn)
            chk("pen_flag", {15'h0, exp_flag}, {15'h0, pen_flag});
        if (resetn && pal_chk && !skip)
            chk("pixel_irgb", {12'h0, exp_px}, {12'h0, pixel_irgb});
    end

    initial
    begin
        #400000;
        errors++;
        complete_run();
    end

    initial
    begin
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        resetn = 1'h1;
        i_host_io_model.io_read(10'h3D9, rd_v);
        chk("select reset", 16'h0000, 16'(rd_v));
        i_host_io_model.io_read(10'h3B8, rd_v);
        chk("other base", 16'h00FF, 16'(rd_v));
        for (int i = 0; i < 6; i++)
        begin
            r = rnd();
            mreg = r[7:0];
            i_host_io_model.io_write(10'h3D8, mreg);
            i_host_io_model.io_read(10'h3D8, rd_v);
            chk("colour mode", 16'(mreg & 8'h3F), 16'(rd_v));
        end
        $display("test colour_mode done");
        frz = 1'h1;
        for (int i = 0; i < 6; i++)
        begin
            r = rnd();
            mreg = pal_mode[i % 3];
            sreg = {2'h0, r[5:0]};
            i_host_io_model.io_write(10'h3D8, mreg);
            i_host_io_model.io_write(10'h3D9, sreg);
            @(negedge ref_clk);
            pal_chk = 1'h1;
            repeat (16) @(negedge ref_clk);
            pal_chk = 1'h0;
            if (!mreg[4])
                chk("border", 16'(sreg[3:0]), 16'(border_irgb));
        end
        frz = 1'h0;
        $display("test palette done");
        for (int i = 0; i < 24; i++)
        begin
            r = rnd();
            compat_mode = legacy_regs_pkg::compat_t'(r[1:0]);
            colour_base = r[2];
            i_host_io_model.io_read(r[2] ? 10'h3DA : 10'h3BA, rd_v);
            chk("status", 16'(exp_st(r[2], crt_s)), 16'(rd_v));
        end
        $display("test status done");
        compat_mode = legacy_regs_pkg::MODE_VGA;
        colour_base = 1'h1;
        i_host_io_model.io_write(10'h3D4, 8'h10);
        i_host_io_model.io_read(10'h3D5, rd_v);
        chk("vga pen", 16'h00FF, 16'(rd_v));
        compat_mode = legacy_regs_pkg::MODE_MONO_TEXT;
        colour_base = 1'h0;
        i_host_io_model.io_write(10'h3B8, 8'hFF);
        i_host_io_model.io_read(10'h3B8, rd_v);
        chk("text mode", 16'h0028, 16'(rd_v));
        compat_mode = legacy_regs_pkg::MODE_MONO_GRAPH;
        for (int i = 0; i < 4; i++)
        begin
            i_host_io_model.io_write(10'h3BF, {6'h00, i[1:0]});
            i_host_io_model.io_write(10'h3B8, 8'h8A);
            @(negedge ref_clk);
            chk("page", 16'(i[1]), 16'(display_ctrl.display_page_select));
            chk("graphics", 16'(i[0]), 16'(display_ctrl.graphics_select));
            chk("mono video", 16'h0001, 16'(display_ctrl.video_on));
        end
        $display("test mono done");
        for (int i = 0; i < 4; i++)
        begin
            compat_mode = i[1] ? legacy_regs_pkg::MODE_MONO_GRAPH : legacy_regs_pkg::MODE_COLOUR;
            colour_base = !i[1];
            i_host_io_model.pen_sample(i[1] ? 10'h3B0 : 10'h3D0, pen_v);
            chk("pen address", {2'h0, exp_pen}, pen_v);
            i_host_io_model.io_write(i[1] ? 10'h3DB : 10'h3BB, 8'h00);
        end
        $display("test pen done");
        complete_run();
    end
endmodule : legacy_text_graphics_regs_tb
`default_nettype wire
